// ===== include/adcpp_consts.svh
// constants for the result post-processing path: offsets, fields, resets, timing
// assumes one 125 MHz clock and a word-indexed register port
`ifndef ADCPP_CONSTS_SVH
`define ADCPP_CONSTS_SVH

// register map, address is {kind, channel}
`define ADCPP_KIND_CFG      4'h0
`define ADCPP_KIND_GAIN     4'h1
`define ADCPP_KIND_OFFSET   4'h2
`define ADCPP_KIND_HIGH     4'h3
`define ADCPP_KIND_LOW      4'h4
`define ADCPP_ADDR_CTRL     8'h50
`define ADCPP_ADDR_STATUS   8'h51
`define ADCPP_ADDR_ALERT    8'h52

// channel_config_reg fields
`define ADCPP_CFG_RATIO_LSB 0
`define ADCPP_CFG_RATIO_MSB 1
`define ADCPP_CFG_LIMIT_EN  2
`define ADCPP_CFG_BIPOLAR   3

// control register fields
`define ADCPP_CTRL_MODE_LSB 0
`define ADCPP_CTRL_MODE_MSB 1
`define ADCPP_CTRL_AUTO     2
`define ADCPP_CTRL_BUSY_EN  3

// reset values
`define ADCPP_CFG_RST       4'h0
`define ADCPP_GAIN_RST      16'h8000
`define ADCPP_OFFSET_RST    16'h0000
`define ADCPP_HIGH_RST      12'hFFF
`define ADCPP_LOW_RST       12'h000
`define ADCPP_CTRL_RST      4'h0

// timing
`define ADCPP_CLK_MHZ        125
`define ADCPP_AUTO_PERIOD_NS 1000
`define ADCPP_AUTO_PERIOD_CYC ((`ADCPP_AUTO_PERIOD_NS * `ADCPP_CLK_MHZ) / 1000)

`endif

// ===== include/adcpp_pkg.sv
// types shared by the post-processing path
// assumes adcpp_consts.svh carries all numeric constants
package adcpp_pkg;
  // sequencing / command mode, order matches the control register code
  typedef enum logic [1:0] {
    ADCPP_SEQ_STANDARD,
    ADCPP_SEQ_ADVANCED,
    ADCPP_CMD_TWO_CYCLE,
    ADCPP_CMD_SINGLE_CYCLE
  } adcpp_mode_t;

  // oversample_ratio_select code: 1, 4, 16, 64
  typedef enum logic [1:0] {
    ADCPP_RATIO_1,
    ADCPP_RATIO_4,
    ADCPP_RATIO_16,
    ADCPP_RATIO_64
  } adcpp_ratio_t;
endpackage : adcpp_pkg

// ===== hw/adcpp_top.sv
// result post-processing: averager, offset/gain correction, limit check, busy
// assumes the conversion core hands samples on mclk with their channel number,
// and conversion_start arrives asynchronously from a pin
`timescale 1ns/100ps
`include "adcpp_consts.svh"
`default_nettype none

module adcpp_top #(
  parameter int NUM_CH          = 16,
  parameter int AUTO_PERIOD_CYC = `ADCPP_AUTO_PERIOD_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        conversion_start,
  output logic             auto_conversion_start,
  input  wire logic        sample_valid,
  input  wire logic [15:0] sample_data,
  input  wire logic [3:0]  sample_chan,
  output logic             result_valid,
  output logic      [18:0] result_data,
  output logic      [3:0]  result_chan,
  output logic      [1:0]  result_ratio,
  output logic             any_limit_alert,
  output logic             busy_alert_pin0
);

  // configuration storage
  logic [3:0]  channel_config_reg     [NUM_CH];
  logic [15:0] channel_gain_reg       [NUM_CH];
  logic [15:0] channel_offset_reg     [NUM_CH];
  logic [11:0] channel_high_limit_reg [NUM_CH];
  logic [11:0] channel_low_limit_reg  [NUM_CH];
  logic [3:0]  ctrl_r;
  logic [15:0] channel_high_alert_flag;
  logic [15:0] channel_low_alert_flag;
  logic [31:0] rdata_nxt;
  adcpp_pkg::adcpp_mode_t mode;
  logic        std_seq;
  logic [3:0]  channel_zero_config_reg;

  assign mode    = adcpp_pkg::adcpp_mode_t'(ctrl_r[`ADCPP_CTRL_MODE_MSB:`ADCPP_CTRL_MODE_LSB]);
  assign std_seq = (mode == adcpp_pkg::ADCPP_SEQ_STANDARD);
  assign channel_zero_config_reg = channel_config_reg[0];

  // register writes; host must zero the ratio before command modes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `ADCPP_CTRL_RST;
      for (int i = 0; i < NUM_CH; i++) begin
        channel_config_reg[i]     <= `ADCPP_CFG_RST;
        channel_gain_reg[i]       <= `ADCPP_GAIN_RST;
        channel_offset_reg[i]     <= `ADCPP_OFFSET_RST;
        channel_high_limit_reg[i] <= `ADCPP_HIGH_RST;
        channel_low_limit_reg[i]  <= `ADCPP_LOW_RST;
      end
    end else if (reg_wr) begin
      if (reg_addr[7:4] == `ADCPP_KIND_CFG) begin
        channel_config_reg[reg_addr[3:0]] <= reg_wdata[3:0];
      end else if (reg_addr[7:4] == `ADCPP_KIND_GAIN) begin
        channel_gain_reg[reg_addr[3:0]] <= reg_wdata[15:0];
      end else if (reg_addr[7:4] == `ADCPP_KIND_OFFSET) begin
        channel_offset_reg[reg_addr[3:0]] <= reg_wdata[15:0];
      end else if (reg_addr[7:4] == `ADCPP_KIND_HIGH) begin
        channel_high_limit_reg[reg_addr[3:0]] <= reg_wdata[11:0];
      end else if (reg_addr[7:4] == `ADCPP_KIND_LOW) begin
        channel_low_limit_reg[reg_addr[3:0]] <= reg_wdata[11:0];
      end else if (reg_addr == `ADCPP_ADDR_CTRL) begin
        ctrl_r <= reg_wdata[3:0];
      end
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (reg_addr[7:4] == `ADCPP_KIND_CFG) begin
      rdata_nxt = {28'h0000000, channel_config_reg[reg_addr[3:0]]};
    end else if (reg_addr[7:4] == `ADCPP_KIND_GAIN) begin
      rdata_nxt = {16'h0000, channel_gain_reg[reg_addr[3:0]]};
    end else if (reg_addr[7:4] == `ADCPP_KIND_OFFSET) begin
      rdata_nxt = {16'h0000, channel_offset_reg[reg_addr[3:0]]};
    end else if (reg_addr[7:4] == `ADCPP_KIND_HIGH) begin
      rdata_nxt = {20'h00000, channel_high_limit_reg[reg_addr[3:0]]};
    end else if (reg_addr[7:4] == `ADCPP_KIND_LOW) begin
      rdata_nxt = {20'h00000, channel_low_limit_reg[reg_addr[3:0]]};
    end else if (reg_addr == `ADCPP_ADDR_CTRL) begin
      rdata_nxt = {28'h0000000, ctrl_r};
    end else if (reg_addr == `ADCPP_ADDR_STATUS) begin
      rdata_nxt = {30'h0, busy_alert_pin0, any_limit_alert};
    end else if (reg_addr == `ADCPP_ADDR_ALERT) begin
      rdata_nxt = {channel_low_alert_flag, channel_high_alert_flag};
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // start pin synchroniser; first stage feeds only the second
  logic start_meta_r;
  logic start_sync_r;
  logic start_prev_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      start_meta_r <= 1'b0;
      start_sync_r <= 1'b0;
      start_prev_r <= 1'b0;
    end else begin
      start_meta_r <= conversion_start;
      start_sync_r <= start_meta_r;
      start_prev_r <= start_sync_r;
    end
  end

  // autocycle start generator, one pulse per conversion period
  logic [$clog2(AUTO_PERIOD_CYC+1)-1:0] auto_cnt_r;
  logic                                 auto_on;
  assign auto_on = ctrl_r[`ADCPP_CTRL_AUTO];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      auto_cnt_r            <= '0;
      auto_conversion_start <= 1'b0;
    end else if (!auto_on) begin
      auto_cnt_r            <= '0;
      auto_conversion_start <= 1'b0;
    end else if (auto_cnt_r == $bits(auto_cnt_r)'(AUTO_PERIOD_CYC - 1)) begin
      auto_cnt_r            <= '0;
      auto_conversion_start <= 1'b1;
    end else begin
      auto_cnt_r            <= auto_cnt_r + 1'b1;
      auto_conversion_start <= 1'b0;
    end
  end

  logic start_evt;
  assign start_evt = (start_sync_r & ~start_prev_r) | auto_conversion_start;

  // effective ratio per incoming sample
  logic [1:0] eff_ratio;
  logic       samp_bip;
  logic [6:0] ratio_n;
  assign eff_ratio = std_seq ? channel_zero_config_reg[1:0]
                             : channel_config_reg[sample_chan][1:0];
  assign samp_bip  = channel_config_reg[sample_chan][`ADCPP_CFG_BIPOLAR];
  always_comb begin
    case (eff_ratio)
      2'h0:    ratio_n = 7'h01;
      2'h1:    ratio_n = 7'h04;
      2'h2:    ratio_n = 7'h10;
      default: ratio_n = 7'h40;
    endcase
  end

  // averager: accumulate ratio samples of one channel
  logic signed [21:0] acc_r;
  logic        [6:0]  cnt_r;
  logic        [3:0]  acc_ch_r;
  logic               restart;
  logic signed [21:0] samp_ext;
  logic signed [21:0] sum_nxt;
  logic        [6:0]  cnt_base;
  logic               sample_last;
  // ratio one never folds in a partial sum left by an earlier ratio
  assign restart  = (cnt_r == 7'h00) || (sample_chan != acc_ch_r) || (eff_ratio == 2'h0);
  assign samp_ext = samp_bip ? {{6{sample_data[15]}}, sample_data} : {6'h00, sample_data};
  assign sum_nxt  = (restart ? 22'sh000000 : acc_r) + samp_ext;
  assign cnt_base = restart ? 7'h00 : cnt_r;
  assign sample_last = (7'(cnt_base + 7'h01) == ratio_n);

  logic signed [21:0] avg_r;
  logic               avg_valid_r;
  logic        [3:0]  avg_ch_r;
  logic        [1:0]  avg_ratio_r;
  logic               avg_bip_r;

  // a channel change mid-block discards the partial sum
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r       <= 22'sh000000;
      cnt_r       <= 7'h00;
      acc_ch_r    <= 4'h0;
      avg_r       <= 22'sh000000;
      avg_valid_r <= 1'b0;
      avg_ch_r    <= 4'h0;
      avg_ratio_r <= 2'h0;
      avg_bip_r   <= 1'b0;
    end else begin
      avg_valid_r <= 1'b0;
      if (sample_valid) begin
        acc_ch_r <= sample_chan;
        if (sample_last) begin
          // ratio one shifts by zero: straight pass
          avg_r       <= sum_nxt >>> eff_ratio;
          avg_valid_r <= 1'b1;
          avg_ch_r    <= sample_chan;
          avg_ratio_r <= eff_ratio;
          avg_bip_r   <= samp_bip;
          cnt_r       <= 7'h00;
        end else begin
          acc_r <= sum_nxt;
          cnt_r <= 7'(cnt_base + 7'h01);
        end
      end
    end
  end

  // correction: (in + offset >>> (3 - ratio)) * gain / 2^15, then clamp to width
  logic signed [21:0] off_s;
  logic signed [21:0] corr_sum;
  logic signed [38:0] prod;
  logic signed [38:0] scaled;
  logic signed [38:0] sat_max;
  logic signed [38:0] sat_min;
  logic signed [38:0] sat_val;
  logic        [4:0]  res_w;
  logic        [15:0] off_raw;
  assign off_raw  = channel_offset_reg[avg_ch_r];
  assign off_s    = $signed({{6{off_raw[15]}}, off_raw}) >>> (2'h3 - avg_ratio_r);
  assign corr_sum = avg_r + off_s;
  assign prod     = 39'(corr_sum) * $signed({1'b0, channel_gain_reg[avg_ch_r]});
  assign scaled   = prod >>> 15;
  assign res_w    = 5'(5'h10 + {3'h0, avg_ratio_r});
  always_comb begin
    if (avg_bip_r) begin
      sat_max = (39'sh1 <<< (res_w - 5'h01)) - 39'sh1;
      sat_min = -(39'sh1 <<< (res_w - 5'h01));
    end else begin
      sat_max = (39'sh1 <<< res_w) - 39'sh1;
      sat_min = 39'sh0;
    end
    if (scaled > sat_max) begin
      sat_val = sat_max;
    end else if (scaled < sat_min) begin
      sat_val = sat_min;
    end else begin
      sat_val = scaled;
    end
  end

  logic signed [19:0] res_s_r;
  logic               res_bip_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      result_valid <= 1'b0;
      result_data  <= 19'h00000;
      result_chan  <= 4'h0;
      result_ratio <= 2'h0;
      res_s_r      <= 20'sh00000;
      res_bip_r    <= 1'b0;
    end else begin
      result_valid <= avg_valid_r;
      if (avg_valid_r) begin
        // low res_w bits only; bits above read zero
        result_data  <= sat_val[18:0] & 19'((39'sh1 <<< res_w) - 39'sh1);
        result_chan  <= avg_ch_r;
        result_ratio <= avg_ratio_r;
        res_s_r      <= sat_val[19:0];
        res_bip_r    <= avg_bip_r;
      end
    end
  end

  // limits scaled to the current width, signed when bipolar
  logic [11:0]        hi_raw;
  logic [11:0]        lo_raw;
  logic signed [19:0] thr_hi;
  logic signed [19:0] thr_lo;
  logic [4:0]         thr_sh;
  logic               limit_check_enable;
  assign hi_raw = channel_high_limit_reg[result_chan];
  assign lo_raw = channel_low_limit_reg[result_chan];
  assign thr_sh = 5'(5'h04 + {3'h0, result_ratio});
  assign thr_hi = (res_bip_r ? {{8{hi_raw[11]}}, hi_raw} : {8'h00, hi_raw}) <<< thr_sh;
  assign thr_lo = (res_bip_r ? {{8{lo_raw[11]}}, lo_raw} : {8'h00, lo_raw}) <<< thr_sh;
  assign limit_check_enable  = std_seq ? channel_zero_config_reg[`ADCPP_CFG_LIMIT_EN]
                          : channel_config_reg[result_chan][`ADCPP_CFG_LIMIT_EN];

  // sticky flags; read of alert register clears, a same-cycle set wins
  logic [15:0] hi_set;
  logic [15:0] lo_set;
  logic        alert_rd;
  assign alert_rd = reg_rd && (reg_addr == `ADCPP_ADDR_ALERT);
  always_comb begin
    hi_set = 16'h0000;
    lo_set = 16'h0000;
    if (result_valid && limit_check_enable) begin
      hi_set[result_chan] = (res_s_r >= thr_hi);
      lo_set[result_chan] = (res_s_r <= thr_lo);
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      channel_high_alert_flag <= 16'h0000;
      channel_low_alert_flag  <= 16'h0000;
    end else begin
      channel_high_alert_flag <= (alert_rd ? 16'h0000 : channel_high_alert_flag) | hi_set;
      channel_low_alert_flag  <= (alert_rd ? 16'h0000 : channel_low_alert_flag) | lo_set;
    end
  end
  assign any_limit_alert = |{channel_high_alert_flag, channel_low_alert_flag};

  // busy: high from start edge until the final result, set beats clear
  logic busy_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
    end else if (start_evt) begin
      busy_r <= 1'b1;
    end else if (avg_valid_r) begin
      busy_r <= 1'b0;
    end
  end
  assign busy_alert_pin0 = busy_r & ctrl_r[`ADCPP_CTRL_BUSY_EN];

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_pass_through: assert property (
    sample_valid && eff_ratio == 2'h0 |=> avg_valid_r && avg_r == $past(samp_ext))
    else $error("ratio one sample not passed straight");
  chk_one_result: assert property (
    sample_valid && sample_last |=> avg_valid_r ##1 result_valid)
    else $error("final sample did not give one result");
  chk_no_early: assert property (
    !(sample_valid && sample_last) |=> !avg_valid_r)
    else $error("result without final sample");
  chk_result_width: assert property (
    result_valid |-> (result_data >> (5'h10 + {3'h0, result_ratio})) == 19'h00000)
    else $error("result wider than ratio allows");
  chk_unipolar_range: assert property (
    result_valid && !res_bip_r |-> (res_s_r >>> (5'h10 + {3'h0, result_ratio})) == 20'sh00000)
    else $error("unipolar result outside its width");
  chk_std_ratio: assert property (
    sample_valid && sample_last && std_seq |=> avg_ratio_r == $past(channel_zero_config_reg[1:0]))
    else $error("standard sequencer ratio not from channel zero");
  chk_unity_corr: assert property (
    avg_valid_r && off_raw == 16'h0000 && channel_gain_reg[avg_ch_r] == 16'h8000
      && avg_r >= 22'sh0 && avg_r < (22'sh1 <<< res_w) && !avg_bip_r
    |=> res_s_r == 20'($past(avg_r)))
    else $error("neutral correction changed the result");
  chk_high_set: assert property (
    result_valid && limit_check_enable && res_s_r >= thr_hi |=> channel_high_alert_flag[$past(result_chan)])
    else $error("upper alert flag not set");
  chk_flag_hold: assert property (
    !result_valid && !alert_rd |=> $stable(channel_high_alert_flag) && $stable(channel_low_alert_flag))
    else $error("alert flags changed without result");
  chk_summary_rise: assert property (
    $rose(any_limit_alert) |-> $past(result_valid))
    else $error("summary alert rose without result");
  chk_busy_fall: assert property (
    $fell(busy_r) |-> result_valid)
    else $error("busy fell before final result");

  cov_ratio64: cover property (avg_valid_r && avg_ratio_r == 2'h3);
  cov_alert: cover property ($rose(any_limit_alert));
  cov_auto_busy: cover property (auto_conversion_start ##[1:200] $fell(busy_r));

endmodule : adcpp_top

`default_nettype wire

// ===== dv/adcpp_core_model.sv
// behavioural conversion core feeding samples into the post-processing path
// assumes the bench supplies the next channel and code before each start
`timescale 1ns/100ps
`default_nettype none

module adcpp_core_model (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        trig_pin,
  input  wire logic        trig_auto,
  input  wire logic [3:0]  next_chan,
  input  wire logic [15:0] next_data,
  output logic             sample_valid,
  output logic      [15:0] sample_data,
  output logic      [3:0]  sample_chan
);
  logic [2:0] pin_sync_r;
  logic [3:0] delay_r;

  // start edge or auto pulse launches one conversion, sample three cycles on
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_r   <= 3'h0;
      delay_r      <= 4'h0;
      sample_valid <= 1'b0;
      sample_data  <= 16'h0000;
      sample_chan  <= 4'h0;
    end else begin
      pin_sync_r   <= {pin_sync_r[1:0], trig_pin};
      sample_valid <= (delay_r == 4'h1);
      if ((pin_sync_r[1] && !pin_sync_r[2]) || trig_auto) begin
        delay_r <= 4'h3;
      end else if (delay_r != 4'h0) begin
        delay_r <= delay_r - 4'h1;
      end
      // outside a sample the lines toggle so no stale code can pass for data
      if (delay_r == 4'h1) begin
        sample_data <= next_data;
        sample_chan <= next_chan;
      end else begin
        sample_data <= ~sample_data;
        sample_chan <= ~sample_chan;
      end
    end
  end
endmodule : adcpp_core_model

`default_nettype wire

// ===== dv/adc_result_postprocess_tb.sv
// self-checking bench for the post-processing path, register tasks plus core model
// assumes adcpp_top with a shortened auto period and the core model beside it
`timescale 1ns/100ps
`default_nettype none

module adc_result_postprocess_tb;
  logic        mclk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        conversion_start;
  logic        auto_conversion_start;
  logic        sample_valid;
  logic [15:0] sample_data;
  logic [3:0]  sample_chan;
  logic        result_valid;
  logic [18:0] result_data;
  logic [3:0]  result_chan;
  logic [1:0]  result_ratio;
  logic        any_limit_alert;
  logic        busy_alert_pin0;
  logic [3:0]  next_chan;
  logic [15:0] next_data;
  logic [31:0] last_res;
  int          res_cnt;
  int          smp_cnt;
  int          smp_at_res;
  int          n0;
  int          mismatches;
  int          comparisons;

  adcpp_top #(.AUTO_PERIOD_CYC(4)) dut (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conversion_start(conversion_start), .auto_conversion_start(auto_conversion_start),
    .sample_valid(sample_valid), .sample_data(sample_data), .sample_chan(sample_chan),
    .result_valid(result_valid), .result_data(result_data), .result_chan(result_chan),
    .result_ratio(result_ratio), .any_limit_alert(any_limit_alert),
    .busy_alert_pin0(busy_alert_pin0));

  adcpp_core_model core (
    .mclk(mclk), .rst_n(rst_n), .trig_pin(conversion_start),
    .trig_auto(auto_conversion_start), .next_chan(next_chan), .next_data(next_data),
    .sample_valid(sample_valid), .sample_data(sample_data), .sample_chan(sample_chan));

  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // result and sample monitor, one process so counts agree at each edge
  always @(posedge mclk) begin
    if (sample_valid === 1'b1) smp_cnt++;
    if (result_valid === 1'b1) begin
      res_cnt++;
      smp_at_res = smp_cnt;
      last_res = {7'h00, result_chan, result_ratio, result_data};
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 check(reg_rdata, exp, what);
  endtask : rdchk

  // one pin start; long enough for sample, result and flag update to land
  task automatic conv(input logic [3:0] ch, input logic [15:0] d);
    @(posedge mclk);
    next_chan        <= ch;
    next_data        <= d;
    conversion_start <= 1'b1;
    repeat (2) @(posedge mclk);
    conversion_start <= 1'b0;
    repeat (10) @(posedge mclk);
  endtask : conv

  // expected {chan, ratio, data} of the last result
  function automatic logic [31:0] res(input logic [3:0] ch, input logic [1:0] r,
                                      input logic [18:0] d);
    return {7'h00, ch, r, d};
  endfunction : res

  task automatic results;
    $display("counts: comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // watchdog: the whole sequence needs about 1400 cycles
  initial begin
    #100000;
    mismatches++;
    results();
  end

  initial begin
    rst_n = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
    conversion_start = 1'b0; next_chan = 4'h0; next_data = 16'h0000;
    res_cnt = 0; smp_cnt = 0; smp_at_res = 0; mismatches = 0; comparisons = 0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk(8'h10, 32'h8000, "gain reset");
    rdchk(8'h33, 32'h0FFF, "high limit reset");
    rdchk(8'h60, 32'h0, "unmapped read");
    rdchk(8'h50, 32'h0, "ctrl reset");
    $display("test reset values done");
    wr(8'h50, 32'h1);
    conv(4'h2, 16'h1234);
    check(last_res, res(4'h2, 2'h0, 19'h01234), "passthrough");
    $display("test passthrough done");
    // ratio four, no result until the fourth start
    wr(8'h01, 32'h1);
    n0 = res_cnt;
    for (int i = 0; i < 3; i++) conv(4'h1, 16'h1000 + 16'(i));
    check(32'(res_cnt - n0), 32'h0, "early result");
    conv(4'h1, 16'h1003);
    check(32'(res_cnt - n0), 32'h1, "one result");
    check(last_res, res(4'h1, 2'h1, 19'h02003), "ratio4 avg");
    wr(8'h21, 32'h0100);
    wr(8'h11, 32'h4000);
    for (int i = 0; i < 4; i++) conv(4'h1, 16'h1000 + 16'(i));
    check(last_res, res(4'h1, 2'h1, 19'h01021), "offset gain");
    // ratio 64: the offset LSB counts in full
    wr(8'h03, 32'h3);
    wr(8'h23, 32'h0001);
    for (int i = 0; i < 64; i++) conv(4'h3, 16'h0400);
    check(last_res, res(4'h3, 2'h3, 19'h02001), "ratio64 offset");
    $display("test averaging and correction done");
    // standard sequencer: channel zero ratio and limit enable rule all
    wr(8'h50, 32'h0);
    wr(8'h00, 32'h2);
    wr(8'h05, 32'h4);
    wr(8'h35, 32'h0);
    n0 = res_cnt;
    for (int i = 0; i < 16; i++) conv(4'h5, 16'h0800);
    check(32'(res_cnt - n0), 32'h1, "std count");
    check(last_res, res(4'h5, 2'h2, 19'h02000), "std ratio");
    rdchk(8'h52, 32'h0, "std limit off");
    $display("test standard sequencer done");
    wr(8'h50, 32'h1);
    wr(8'h16, 32'hFFFF);
    conv(4'h6, 16'hFFFF);
    check(last_res, res(4'h6, 2'h0, 19'h0FFFF), "saturate");
    $display("test saturation done");
    // command mode: ratios zeroed by the host, own limit enables
    wr(8'h01, 32'h0);
    wr(8'h03, 32'h0);
    wr(8'h50, 32'h2);
    wr(8'h07, 32'h4);
    wr(8'h37, 32'h100);
    wr(8'h47, 32'h080);
    conv(4'h7, 16'h1000);
    check(32'(any_limit_alert), 32'h1, "alert pin");
    rdchk(8'h51, 32'h1, "status alert");
    rdchk(8'h52, 32'h0000_0080, "high flag");
    rdchk(8'h52, 32'h0, "flags cleared");
    conv(4'h7, 16'h0800);
    rdchk(8'h52, 32'h0080_0000, "low flag");
    wr(8'h50, 32'h3);
    wr(8'h08, 32'hC);
    wr(8'h38, 32'h7FF);
    wr(8'h48, 32'h0);
    conv(4'h8, 16'hFFF0);
    rdchk(8'h52, 32'h0100_0000, "signed compare");
    rdchk(8'h51, 32'h0, "status clear");
    $display("test limits done");
    // busy falls only with the averaged result
    wr(8'h50, 32'h9);
    wr(8'h01, 32'h1);
    wr(8'h21, 32'h0);
    wr(8'h11, 32'h8000);
    for (int i = 0; i < 4; i++) begin
      conv(4'h1, 16'h2000);
      check(32'(busy_alert_pin0), (i < 3) ? 32'h1 : 32'h0, "busy");
    end
    $display("test busy done");
    // autocycle: internal starts, result still after four samples
    wr(8'h50, 32'h5);
    n0 = res_cnt;
    smp_cnt = 0;
    for (int i = 0; i < 200 && res_cnt == n0; i++) @(posedge mclk);
    check(32'(smp_at_res), 32'h4, "auto ratio wait");
    check(last_res, res(4'h1, 2'h1, 19'h04000), "auto result");
    wr(8'h50, 32'h1);
    $display("test autocycle done");
    results();
  end
endmodule : adc_result_postprocess_tb

`default_nettype wire
